// [hw/isw_cond_detect.sv]
`timescale 1ns/1ps
module isw_cond_detect
  import isw_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      start_o,
  output logic      stop_o
);

  isw_edge_s st;
  isw_edge_s next_st;

  //------------------------------------------------------------
  // pin sampling and condition detect
  //------------------------------------------------------------
  // only the second sync stage feeds the edge logic
  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], scl_i};
    next_st.sda_sync = {st.sda_sync[0], sda_i};
    next_st.scl_last = st.scl_sync[1];
    next_st.sda_last = st.sda_sync[1];
    // sda moving while scl stays high marks start or stop
    next_st.start_det = st.scl_sync[1] & st.scl_last & st.sda_last & ~st.sda_sync[1];
    next_st.stop_det = st.scl_sync[1] & st.scl_last & ~st.sda_last & st.sda_sync[1];
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_last: 1'b1, sda_last: 1'b1,
              start_det: 1'b0, stop_det: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign start_o = st.start_det;
  assign stop_o = st.stop_det;

  chk_no_dual_cond: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !(start_o && stop_o)) else $error("start and stop seen together");

endmodule

// [hw/isw_status_wake.sv]
`timescale 1ns/1ps
module isw_status_wake
  import isw_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        low_power_i,
  input  wire logic        addr_valid_i,
  input  wire logic [7:0]  addr_byte_i,
  input  wire logic        byte_start_i,
  input  wire logic        byte_done_i,
  input  wire logic        byte_is_addr_i,
  input  wire logic        arb_lost_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             dma_req_o,
  output logic             wake_o,
  output logic             slave_hit_o,
  output logic             bus_busy_o,
  output logic             tx_mode_o,
  output logic [7:0]       tx_data_o
);

  isw_state_s st;
  isw_state_s next_st;

  logic       start_det;
  logic       stop_det;
  logic [5:0] idx;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       ctl_wr;
  logic       tx;
  logic       prim_match;
  logic       gc_match;
  logic       any_match;
  logic       range_match;
  logic       hit;
  logic       tcf_clr_sw;
  logic       dma_evt;

  isw_cond_detect u_cond (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .start_o (start_det),
    .stop_o  (stop_det)
  );

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic reg_mapped(input logic [5:0] i);
    case (i)
      IDX_PRIMARY, IDX_FIRST_CTRL, IDX_STATUS, IDX_DATA,
      IDX_OPTION, IDX_SECOND, IDX_RANGE: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction

  // inclusive window, either bound may be the lower one
  function automatic logic in_range(input logic [6:0] a, input logic [6:0] b, input logic [6:0] c);
    if (b <= c) begin
      in_range = (a >= b) && (a <= c);
    end else begin
      in_range = (a >= c) && (a <= b);
    end
  endfunction

  function automatic logic [7:0] status_byte(input isw_state_s s);
    status_byte = {s.byte_done_flag, s.slave_hit_flag, s.bus_busy, s.arb_lost_flag,
                   s.range_hit_flag, s.slave_dir_flag, 2'b00};
  endfunction

  //------------------------------------------------------------
  // bus decode
  //------------------------------------------------------------
  assign idx = paddr_i[7:2];
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign ctl_wr = wr & (idx == IDX_FIRST_CTRL);
  assign tx = st.first_control[FC_TX_MODE];

  //------------------------------------------------------------
  // address matching
  //------------------------------------------------------------
  assign prim_match = addr_byte_i[7:1] == st.primary;
  assign gc_match = st.option[OP_GENERAL_CALL] & (addr_byte_i[7:1] == GENERAL_CALL_ADDR);
  // a zero range register never matches on its own
  assign range_match = ((st.range_a != RST_ADDR) && (addr_byte_i[7:1] == st.range_a))
                     | (st.option[OP_RANGE_MATCH] & in_range(addr_byte_i[7:1], st.primary, st.range_a));
  assign any_match = prim_match | gc_match | range_match
                   | (st.option[OP_SECOND_ADDR] & (addr_byte_i[7:1] == st.second))
                   | (st.option[OP_ALERT_RESP] & (addr_byte_i[7:1] == ALERT_RESP_ADDR));
  assign hit = addr_valid_i & any_match;

  assign tcf_clr_sw = (acc & (idx == IDX_DATA) & ((~pwrite_i & ~tx) | (pwrite_i & tx)));

  // fast ack only keeps the transmit side as a trigger
  always_comb begin
    if (st.option[OP_FAST_ACK]) begin
      dma_evt = byte_done_i & tx;
    end else begin
      dma_evt = (byte_done_i & (tx | ~byte_is_addr_i))
              | (addr_valid_i & (prim_match | gc_match));
    end
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (psel_i & ~penable_i) begin
      case (idx)
        IDX_PRIMARY:    next_st.rdata = {24'h000000, st.primary, 1'b0};
        IDX_FIRST_CTRL: next_st.rdata = {24'h000000, st.first_control};
        IDX_STATUS:     next_st.rdata = {24'h000000, status_byte(st)};
        IDX_DATA:       next_st.rdata = {24'h000000, st.rx_data};
        IDX_OPTION:     next_st.rdata = {24'h000000, st.option};
        IDX_SECOND:     next_st.rdata = {24'h000000, st.second, 1'b0};
        IDX_RANGE:      next_st.rdata = {24'h000000, st.range_a, 1'b0};
        default:        next_st.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_PRIMARY:    next_st.primary = pwdata_i[7:1];
        IDX_FIRST_CTRL: next_st.first_control = pwdata_i[7:0];
        IDX_DATA:       next_st.tx_data = pwdata_i[7:0];
        IDX_OPTION:     next_st.option = pwdata_i[7:0];
        IDX_SECOND:     next_st.second = pwdata_i[7:1];
        IDX_RANGE:      next_st.range_a = pwdata_i[7:1];
        default:        next_st.rdata = st.rdata; // status flags take no plain write
      endcase
    end
    if (byte_done_i & ~tx & ~byte_is_addr_i) begin
      next_st.rx_data = rx_data_i;
    end
    // set wins over every clear
    next_st.byte_done_flag = byte_done_i | hit
                           | (st.byte_done_flag & ~byte_start_i & ~tcf_clr_sw);
    // addr_valid arrives ahead of the ack slot
    next_st.slave_hit_flag = hit | (st.slave_hit_flag & ~ctl_wr);
    next_st.range_hit_flag = (addr_valid_i & range_match) | (st.range_hit_flag & ~ctl_wr);
    if (hit) begin
      next_st.slave_dir_flag = addr_byte_i[0];
    end
    if (start_det) begin
      next_st.bus_busy = 1'b1;
    end else if (stop_det) begin
      next_st.bus_busy = 1'b0;
    end
    next_st.arb_lost_flag = arb_lost_i
                          | (st.arb_lost_flag & ~(wr & (idx == IDX_STATUS) & pwdata_i[ST_ARB_LOST]));
    // request holds until software services the data register or clears the dma enable bit
    if (!st.first_control[FC_DMA_EN]) begin
      next_st.dma_req = 1'b0;
    end else begin
      next_st.dma_req = dma_evt | (st.dma_req & ~tcf_clr_sw);
    end
    // limitation: wake holds only while the low power request stays up
    next_st.wake = (hit & low_power_i & st.first_control[FC_WAKE_EN])
                 | (st.wake & low_power_i);
  end

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '{first_control: RST_BYTE, option: RST_BYTE, primary: RST_ADDR, second: RST_ADDR,
              range_a: RST_ADDR, tx_data: RST_BYTE, rx_data: RST_BYTE, byte_done_flag: 1'b0,
              slave_hit_flag: 1'b0, bus_busy: 1'b0, arb_lost_flag: 1'b0, range_hit_flag: 1'b0,
              slave_dir_flag: 1'b0, dma_req: 1'b0, wake: 1'b0, rdata: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // read data is captured in setup so the access phase needs no wait
  assign prdata_o = st.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & (~reg_mapped(idx) | (paddr_i[1:0] != 2'b00));
  assign dma_req_o = st.dma_req;
  assign wake_o = st.wake;
  assign slave_hit_o = st.slave_hit_flag;
  assign bus_busy_o = st.bus_busy;
  assign tx_mode_o = tx;
  assign tx_data_o = st.tx_data;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_tx_data_write;
    wr && (idx == IDX_DATA) && tx && !byte_done_i && !addr_valid_i;
  endsequence

  sequence seq_ctl_write_quiet;
    ctl_wr && !addr_valid_i;
  endsequence

  chk_dma_off_quiet: assert property (
    !st.first_control[FC_DMA_EN] [*2] |-> !dma_req_o) else $error("dma request while disabled");

  chk_prim_sets_both: assert property (
    addr_valid_i && prim_match |=> slave_hit_o && st.byte_done_flag) else $error("match missed flags");

  chk_done_sets: assert property (
    byte_done_i |=> st.byte_done_flag) else $error("byte done flag not set");

  chk_done_tx_clear: assert property (
    seq_tx_data_write |=> !st.byte_done_flag) else $error("tx data write left done flag");

  chk_arb_holds: assert property (
    st.arb_lost_flag && !(wr && (idx == IDX_STATUS)) |=> st.arb_lost_flag) else $error("arb flag lost");

  chk_arb_sets: assert property (
    arb_lost_i |=> st.arb_lost_flag) else $error("arb loss not flagged");

  chk_busy_start: assert property (
    start_det |=> bus_busy_o) else $error("busy not set");

  chk_busy_hold: assert property (
    bus_busy_o && !stop_det |=> bus_busy_o) else $error("busy not held");

  chk_busy_stop: assert property (
    stop_det && !start_det |=> !bus_busy_o) else $error("busy not cleared");

  chk_ctl_clears: assert property (
    seq_ctl_write_quiet |=> !slave_hit_o && !st.range_hit_flag) else $error("control write kept hit");

  chk_wake_raise: assert property (
    hit && low_power_i && st.first_control[FC_WAKE_EN] |=> wake_o) else $error("no wake on match");

  chk_wake_gated: assert property (
    !st.first_control[FC_WAKE_EN] && !wake_o |=> !wake_o) else $error("wake while disabled");

  chk_status_ro: assert property (
    wr && (idx == IDX_STATUS) && !byte_done_i && !addr_valid_i && !byte_start_i && !start_det && !stop_det
    |=> $stable(st.byte_done_flag) && $stable(slave_hit_o) && $stable(bus_busy_o)) else $error("status written");

  chk_dir_follow: assert property (
    hit |=> st.slave_dir_flag == $past(addr_byte_i[0])) else $error("slave dir mismatch");

endmodule

// [inc/isw_pkg.sv]
//------------------------------------------------------------
//------------------------------------------------------------
package isw_pkg;

  // register indices, byte address is four times index
  localparam logic [5:0] IDX_PRIMARY = 6'h00;
  localparam logic [5:0] IDX_FIRST_CTRL = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_DATA = 6'h04;
  localparam logic [5:0] IDX_OPTION = 6'h05;
  localparam logic [5:0] IDX_SECOND = 6'h06;
  localparam logic [5:0] IDX_RANGE = 6'h07;

  // first_control fields
  localparam int FC_DMA_EN = 0;
  localparam int FC_WAKE_EN = 1;
  localparam int FC_TX_MODE = 4;

  // option fields
  localparam int OP_FAST_ACK = 0;
  localparam int OP_GENERAL_CALL = 1;
  localparam int OP_SECOND_ADDR = 2;
  localparam int OP_ALERT_RESP = 3;
  localparam int OP_RANGE_MATCH = 4;

  // bus_status fields
  localparam int ST_BYTE_DONE = 7;
  localparam int ST_SLAVE_HIT = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_ARB_LOST = 4;
  localparam int ST_RANGE_HIT = 3;
  localparam int ST_SLAVE_DIR = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_ADDR = 7'h00;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  typedef struct packed {
    logic [7:0]  first_control;
    logic [7:0]  option;
    logic [6:0]  primary;
    logic [6:0]  second;
    logic [6:0]  range_a;
    logic [7:0]  tx_data;
    logic [7:0]  rx_data;
    logic        byte_done_flag;
    logic        slave_hit_flag;
    logic        bus_busy;
    logic        arb_lost_flag;
    logic        range_hit_flag;
    logic        slave_dir_flag;
    logic        dma_req;
    logic        wake;
    logic [31:0] rdata;
  } isw_state_s;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_last;
    logic       sda_last;
    logic       start_det;
    logic       stop_det;
  } isw_edge_s;

endpackage

// [test/isw_bus_peer.sv]
`timescale 1ns/1ps
//----------------------------
// far side bus peer
//----------------------------
module isw_bus_peer (
  output logic scl_o,
  output logic sda_o
);
  // pull-ups keep both lines high; the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // non-blocking so a change made at a clock edge never races the sampler
  task automatic send_start();
    sda_o <= 1'b0;
    #62.5 scl_o <= 1'b0;
    #62.5;
  endtask
  task automatic send_stop();
    #62.5 sda_o <= 1'b0;
    #62.5 scl_o <= 1'b1;
    #62.5 sda_o <= 1'b1;
    #62.5;
  endtask
endmodule

// [test/tb_i2c_status_wake_dma_flags.sv]
`timescale 1ns/1ps
module tb_i2c_status_wake_dma_flags;
  import isw_pkg::*;
  //----------------------------
  // signals
  //----------------------------
  localparam logic [7:0] A_PRI = {IDX_PRIMARY, 2'b00};
  localparam logic [7:0] A_FC  = {IDX_FIRST_CTRL, 2'b00};
  localparam logic [7:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [7:0] A_OPT = {IDX_OPTION, 2'b00};
  localparam logic [7:0] A_SEC = {IDX_SECOND, 2'b00};
  localparam logic [7:0] A_RNG = {IDX_RANGE, 2'b00};
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        low_power_i = 1'b0;
  logic        addr_valid_i = 1'b0;
  logic [7:0]  addr_byte_i = 8'h00;
  logic        byte_start_i = 1'b0;
  logic        byte_done_i = 1'b0;
  logic        byte_is_addr_i = 1'b0;
  logic        arb_lost_i = 1'b0;
  logic [7:0]  rx_data_i = 8'h00;
  logic        scl_i;
  logic        sda_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        dma_req_o;
  logic        wake_o;
  logic        slave_hit_o;
  logic        bus_busy_o;
  logic        tx_mode_o;
  logic [7:0]  tx_data_o;
  logic [31:0] rdv;
  logic        err;
  int          mismatches = 0;
  int          checks = 0;

  always #5 clock_i = ~clock_i;

  isw_bus_peer peer (.scl_o(scl_i), .sda_o(sda_i));
  isw_status_wake dut (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .scl_i, .sda_i, .low_power_i, .addr_valid_i, .addr_byte_i,
    .byte_start_i, .byte_done_i, .byte_is_addr_i, .arb_lost_i, .rx_data_i, .dma_req_o, .wake_o,
    .slave_hit_o, .bus_busy_o, .tx_mode_o, .tx_data_o);

  //----------------------------
  // shared tasks
  //----------------------------
  task automatic conclude();
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // one idle edge after each transfer so psel is never assigned twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rdv = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic hit(input logic [6:0] a, input logic rw);
    addr_byte_i <= {a, rw};
    addr_valid_i <= 1'b1;
    @(posedge clock_i);
    addr_valid_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic done(input logic is_addr);
    byte_is_addr_i <= is_addr;
    byte_done_i <= 1'b1;
    @(posedge clock_i);
    byte_done_i <= 1'b0;
    @(posedge clock_i);
  endtask

  //----------------------------
  // scenarios
  //----------------------------
  task automatic t_reset();
    rd(A_ST);
    chk(rdv, 32'h0);
    chkb(bus_busy_o, 1'b0);
    rd(8'h20);
    chkb(err, 1'b1);
    rd(A_ST | 8'h01);
    chkb(err, 1'b1);
  endtask
  task automatic t_match();
    wr(A_PRI, 8'h20);
    low_power_i <= 1'b1;
    hit(7'h10, 1'b1);
    chkb(dma_req_o, 1'b0);
    chkb(wake_o, 1'b0);
    wr(A_FC, 8'h03);
    hit(7'h10, 1'b1);
    chkb(slave_hit_o, 1'b1);
    chkb(dma_req_o, 1'b1);
    chkb(wake_o, 1'b1);
    rd(A_ST);
    chk(rdv, 32'hc4);
    low_power_i <= 1'b0;
    wr(A_FC, {3'h0, rdv[ST_SLAVE_DIR], 4'h0});
    chkb(tx_mode_o, 1'b1);
    chkb(wake_o, 1'b0);
    rd(A_ST);
    chk(rdv & 32'h48, 32'h0);
    chkb(dma_req_o, 1'b0);
  endtask
  task automatic t_bytes();
    wr(A_FC, 8'h11);
    chkb(tx_mode_o, 1'b1);
    byte_start_i <= 1'b1;
    @(posedge clock_i);
    byte_start_i <= 1'b0;
    rd(A_ST);
    chk(rdv & 32'h80, 32'h0);
    done(1'b1);
    chkb(dma_req_o, 1'b1);
    rd(A_ST);
    chk(rdv & 32'h80, 32'h80);
    wr(A_DAT, 8'h5a);
    chk({24'h0, tx_data_o}, 32'h5a);
    chkb(dma_req_o, 1'b0);
    rd(A_ST);
    chk(rdv & 32'h80, 32'h0);
    wr(A_FC, 8'h01);
    rx_data_i <= 8'h3c;
    done(1'b0);
    chkb(dma_req_o, 1'b1);
    rd(A_DAT);
    chk(rdv, 32'h3c);
    chkb(dma_req_o, 1'b0);
    rd(A_ST);
    chk(rdv & 32'h80, 32'h0);
  endtask
  task automatic t_fast();
    wr(A_OPT, 8'h01);
    done(1'b0);
    chkb(dma_req_o, 1'b0);
    hit(7'h10, 1'b0);
    chkb(dma_req_o, 1'b0);
    wr(A_FC, 8'h11);
    done(1'b1);
    chkb(dma_req_o, 1'b1);
  endtask
  task automatic t_addr();
    logic [7:0] op [10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h10};
    logic [6:0] ad [10] = '{7'h10, 7'h30, 7'h00, 7'h00, 7'h20, 7'h20, 7'h0c, 7'h0c, 7'h18, 7'h18};
    logic [7:0] ex [10] = '{8'h40, 8'h48, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h48};
    wr(A_SEC, 8'h40);
    wr(A_RNG, 8'h60);
    for (int i = 0; i < 10; i++) begin
      wr(A_FC, 8'h00);
      wr(A_OPT, op[i]);
      hit(ad[i], 1'b0);
      rd(A_ST);
      chk(rdv & 32'h48, {24'h0, ex[i]});
    end
  endtask
  task automatic t_arb();
    logic [31:0] s;
    arb_lost_i <= 1'b1;
    @(posedge clock_i);
    arb_lost_i <= 1'b0;
    @(posedge clock_i);
    rd(A_ST);
    s = rdv;
    chk(s & 32'h10, 32'h10);
    wr(A_ST, 8'hef);
    rd(A_ST);
    chk(rdv, s);
    wr(A_ST, 8'h10);
    rd(A_ST);
    chk(rdv, s & ~32'h10);
  endtask
  // the sync and detect path needs a few clocks after each pin change
  task automatic t_busy();
    peer.send_start();
    repeat (5) @(posedge clock_i);
    chkb(bus_busy_o, 1'b1);
    rd(A_ST);
    chk(rdv & 32'h20, 32'h20);
    peer.send_stop();
    repeat (5) @(posedge clock_i);
    chkb(bus_busy_o, 1'b0);
  endtask

  //----------------------------
  // main sequence and watchdog
  //----------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_reset();
    t_match();
    t_bytes();
    t_fast();
    t_addr();
    t_arb();
    t_busy();
    conclude();
  end
  // the sequence needs well under 1000 clocks
  initial begin
    #100us;
    mismatches++;
    conclude();
  end
endmodule
